// ### include/irct_pkg.sv
// constants, register map and state types of the infrared counter/timers
package irct_pkg;
  // bus geometry
  localparam int ADDR_W = 14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_BYTE_CTL = 12'hd00;
  localparam logic [11:0] IDX_COMMON = 12'hd01;
  localparam logic [11:0] IDX_WORD_CTL = 12'hd02;
  localparam logic [11:0] IDX_EXT_CTL = 12'hd03;
  localparam logic [11:0] IDX_BYTE_LO_HOLD = 12'hd04;
  localparam logic [11:0] IDX_BYTE_HI_HOLD = 12'hd05;
  localparam logic [11:0] IDX_WORD_LO_HOLD = 12'hd06;
  localparam logic [11:0] IDX_WORD_HI_HOLD = 12'hd07;
  localparam logic [11:0] IDX_WORD_CAP_LO = 12'hd08;
  localparam logic [11:0] IDX_WORD_CAP_HI = 12'hd09;
  localparam logic [11:0] IDX_BYTE_CAP_LO = 12'hd0a;
  localparam logic [11:0] IDX_BYTE_CAP_HI = 12'hd0b;
  // byte and word timer control fields
  localparam int CTL_EN = 7;
  localparam int CTL_SINGLE = 6;
  localparam int CTL_TIMEOUT = 5;
  localparam int CTL_DEMOD = 4;
  localparam int CTL_CAPSTAT = 3;
  localparam int CTL_CAP_IE = 2;
  localparam int CTL_TO_IE = 1;
  localparam int CTL_PIN_EN = 0;
  // common functions fields
  localparam int CMN_SRC_SEL = 6;
  localparam int CMN_EDGE_LSB = 4;
  localparam int CMN_MODE_LSB = 2;
  localparam int CMN_BYTE_INIT = 1;
  localparam int CMN_WORD_INIT = 0;
  // extended control field
  localparam int EXT_CARRIER = 4;
  // reset values
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_CAP = 8'h00;
  // timing: system clock, timer clock, glitch filter widths
  localparam int SYS_CLK_NS = 50;
  localparam int TIMER_CLK_NS = 100;
  localparam int TICK_CYC = (TIMER_CLK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int FILT1_NS = 100;
  localparam int FILT2_NS = 200;
  localparam int FILT3_NS = 400;
  localparam int FILT1_CYC = (FILT1_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int FILT2_CYC = (FILT2_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int FILT3_CYC = (FILT3_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // counter sequence for either timer
  typedef enum logic [1:0] {
    IRCT_IDLE = 2'b00,
    IRCT_ARMED = 2'b01,
    IRCT_RUN = 2'b11
  } irct_state_t;
endpackage : irct_pkg

// ### hdl/irct_timers.sv
// infrared counter/timers: byte and word timers behind an AXI4-Lite slave
`timescale 1ns/1ns
module irct_timers (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [irct_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [irct_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer input sources
  input wire logic primary_timer_input_pin,
  input wire logic primary_comparator_out,
  input wire logic primary_ir_amp_out,
  input wire logic alternate_timer_input_pin,
  input wire logic [1:0] port_three_mode_register,
  // timer outputs and interrupt requests
  output logic byte_timer_output,
  output logic word_timer_output,
  output logic byte_timer_pin_en,
  output logic word_timer_pin_en,
  output logic byte_timeout_irq,
  output logic byte_capture_irq,
  output logic word_timeout_irq,
  output logic word_capture_irq
);
  import irct_pkg::*;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a[ADDR_W-1:2] >= IDX_BYTE_CTL) &&
                (a[ADDR_W-1:2] <= IDX_BYTE_CAP_HI);
  endfunction : is_mapped

  function automatic logic [3:0] filt_len(input logic [1:0] code);
    unique case (code)
      2'b00: filt_len = 4'h1;
      2'b01: filt_len = 4'(FILT1_CYC);
      2'b10: filt_len = 4'(FILT2_CYC);
      2'b11: filt_len = 4'(FILT3_CYC);
    endcase
  endfunction : filt_len

  logic [7:0] ctl8_r, cmn_r, ctl16_r, ext_r;
  logic [7:0] hold8l_r, hold8h_r, hold16l_r, hold16h_r;
  logic [7:0] cap8l_r, cap8h_r;
  logic [15:0] cap16_r;
  logic [1:0] edge8_r;
  logic aw_have_r, w_have_r, w_strb0_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] wd_r;
  logic wr_go, wr_en;
  logic [11:0] widx;

  // ---------------- bus slave ----------------
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_en = wr_go && w_strb0_r && is_mapped(aw_addr_r);
  assign widx = aw_addr_r[ADDR_W-1:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      wd_r <= 8'h00;
      w_strb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wd_r <= s_axi_wdata[7:0];
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr[ADDR_W-1:2])
        IDX_BYTE_CTL: s_axi_rdata[7:0] <= ctl8_r;
        // edge flags show in place of the initial bits during byte timer demodulation
        IDX_COMMON: s_axi_rdata[7:0] <= ctl8_r[CTL_DEMOD] ?
                      {cmn_r[7:2], edge8_r} : cmn_r;
        IDX_WORD_CTL: s_axi_rdata[7:0] <= ctl16_r;
        IDX_EXT_CTL: s_axi_rdata[7:0] <= ext_r;
        IDX_BYTE_LO_HOLD: s_axi_rdata[7:0] <= hold8l_r;
        IDX_BYTE_HI_HOLD: s_axi_rdata[7:0] <= hold8h_r;
        IDX_WORD_LO_HOLD: s_axi_rdata[7:0] <= hold16l_r;
        IDX_WORD_HI_HOLD: s_axi_rdata[7:0] <= hold16h_r;
        IDX_WORD_CAP_LO: s_axi_rdata[7:0] <= cap16_r[7:0];
        IDX_WORD_CAP_HI: s_axi_rdata[7:0] <= cap16_r[15:8];
        IDX_BYTE_CAP_LO: s_axi_rdata[7:0] <= cap8l_r;
        IDX_BYTE_CAP_HI: s_axi_rdata[7:0] <= cap8h_r;
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold8l_r <= RST_HOLD;
      hold8h_r <= RST_HOLD;
      hold16l_r <= RST_HOLD;
      hold16h_r <= RST_HOLD;
      cmn_r <= RST_CTL;
      ext_r <= RST_CTL;
    end else if (wr_en) begin
      if (widx == IDX_BYTE_LO_HOLD) hold8l_r <= wd_r;
      if (widx == IDX_BYTE_HI_HOLD) hold8h_r <= wd_r;
      if (widx == IDX_WORD_LO_HOLD) hold16l_r <= wd_r;
      if (widx == IDX_WORD_HI_HOLD) hold16h_r <= wd_r;
      if (widx == IDX_COMMON) cmn_r <= wd_r;
      if (widx == IDX_EXT_CTL) ext_r <= wd_r & 8'h10;
    end
  end

  // ---------------- input path ----------------
  logic src, flt_r, flt_d_r, evt, rise;
  logic [3:0] fcnt_r;
  logic [$clog2(TICK_CYC+1)-1:0] tcnt_r;
  logic tick;

  assign src = cmn_r[CMN_SRC_SEL] ? alternate_timer_input_pin :
               port_three_mode_register[1] ? primary_ir_amp_out :
               port_three_mode_register[0] ? primary_comparator_out :
               primary_timer_input_pin;

  // glitch filter: level must hold for the full width to pass
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_r <= 1'b0;
      fcnt_r <= 4'h0;
    end else if (src == flt_r) begin
      fcnt_r <= 4'h0;
    end else if (fcnt_r + 4'h1 >= filt_len(cmn_r[CMN_MODE_LSB +: 2])) begin
      flt_r <= src;
      fcnt_r <= 4'h0;
    end else begin
      fcnt_r <= fcnt_r + 4'h1;
    end
  end

  // edge select: 00 rising, 01 falling, 1x both
  assign rise = flt_r && !flt_d_r;
  assign evt = cmn_r[CMN_EDGE_LSB + 1] ? (flt_r != flt_d_r) :
               cmn_r[CMN_EDGE_LSB] ? (!flt_r && flt_d_r) : rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_d_r <= 1'b0;
      tcnt_r <= '0;
    end else begin
      flt_d_r <= flt_r;
      tcnt_r <= (tcnt_r == ($bits(tcnt_r))'(TICK_CYC - 1)) ? '0 : tcnt_r + 1'b1;
    end
  end
  assign tick = (tcnt_r == ($bits(tcnt_r))'(TICK_CYC - 1));

  // ---------------- byte timer ----------------
  irct_state_t st8_r;
  logic [7:0] cnt8_r;
  logic [2:0] ecnt8_r;
  logic out8_r, ph8_r, en8_d_r, dm8, carrier, start8, term8;
  logic arm8, cap8, flag8, to8_set, stop8, wr_ctl8;

  assign dm8 = ctl8_r[CTL_DEMOD];
  assign carrier = ext_r[EXT_CARRIER];
  assign start8 = ctl8_r[CTL_EN] && !en8_d_r;
  assign term8 = tick && st8_r == IRCT_RUN && cnt8_r == 8'h01;
  // third edge starts the count under carrier mode
  assign arm8 = dm8 && st8_r == IRCT_ARMED && evt &&
                (!carrier || ecnt8_r == 3'd2);
  assign cap8 = dm8 && st8_r == IRCT_RUN && evt &&
                (!carrier || ecnt8_r < 3'd5);
  assign flag8 = cap8 && (!carrier || ecnt8_r == 3'd4);
  // repeating mode flags only every second terminal count
  assign to8_set = term8 && (dm8 || ctl8_r[CTL_SINGLE] || ph8_r);
  assign stop8 = term8 && !dm8 && ctl8_r[CTL_SINGLE];
  assign wr_ctl8 = wr_en && widx == IDX_BYTE_CTL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl8_r <= RST_CTL;
    end else begin
      if (wr_ctl8) begin
        ctl8_r[7:6] <= wd_r[7:6];
        ctl8_r[4:0] <= wd_r[4:0];
      end
      // status set wins over a clearing write
      if (to8_set) ctl8_r[CTL_TIMEOUT] <= 1'b1;
      else if (wr_ctl8 && wd_r[CTL_TIMEOUT]) ctl8_r[CTL_TIMEOUT] <= 1'b0;
      if (stop8 && !wr_ctl8) ctl8_r[CTL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st8_r <= IRCT_IDLE;
      cnt8_r <= 8'h00;
      out8_r <= 1'b1;
      ph8_r <= 1'b0;
      ecnt8_r <= 3'd0;
      en8_d_r <= 1'b0;
    end else begin
      en8_d_r <= ctl8_r[CTL_EN];
      if (!ctl8_r[CTL_EN]) begin
        st8_r <= IRCT_IDLE;
        out8_r <= !cmn_r[CMN_BYTE_INIT];
      end else if (start8) begin
        ecnt8_r <= 3'd0;
        ph8_r <= 1'b0;
        if (dm8) begin
          st8_r <= IRCT_ARMED;
        end else begin
          st8_r <= IRCT_RUN;
          out8_r <= cmn_r[CMN_BYTE_INIT];
          cnt8_r <= cmn_r[CMN_BYTE_INIT] ? hold8h_r : hold8l_r;
        end
      end else begin
        if (evt && ecnt8_r != 3'd7) ecnt8_r <= ecnt8_r + 3'd1;
        if (arm8) begin
          st8_r <= IRCT_RUN;
          cnt8_r <= hold8l_r;
        end else if (cap8) begin
          // reload all ones after a capture
          cnt8_r <= 8'hff;
        end else if (tick && st8_r == IRCT_RUN) begin
          if (cnt8_r == 8'h00) begin
            cnt8_r <= 8'hff;
          end else if (cnt8_r == 8'h01) begin
            // demod passes through zero and wraps next tick
            cnt8_r <= 8'h00;
            if (!dm8) begin
              // toggle, then stop or reload by new level
              out8_r <= !out8_r;
              ph8_r <= !ph8_r;
              if (ctl8_r[CTL_SINGLE]) st8_r <= IRCT_IDLE;
              else cnt8_r <= out8_r ? hold8l_r : hold8h_r;
            end
          end else begin
            cnt8_r <= cnt8_r - 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap8l_r <= RST_CAP;
      cap8h_r <= RST_CAP;
      edge8_r <= 2'b00;
    end else begin
      if (cap8 && rise) cap8l_r <= ~cnt8_r;
      if (cap8 && !rise) cap8h_r <= ~cnt8_r;
      // edge flags: set wins over clear
      if (flag8) edge8_r[rise ? 0 : 1] <= 1'b1;
      if (wr_en && widx == IDX_COMMON && dm8) begin
        if (!(flag8 && rise) && wd_r[0]) edge8_r[0] <= 1'b0;
        if (!(flag8 && !rise) && wd_r[1]) edge8_r[1] <= 1'b0;
      end
    end
  end

  // ---------------- word timer ----------------
  irct_state_t st16_r;
  logic [15:0] cnt16_r;
  logic out16_r, en16_d_r, dm16, start16, term16, cap16, to16_set;
  logic stop16, wr_ctl16;

  assign dm16 = ctl16_r[CTL_DEMOD];
  assign start16 = ctl16_r[CTL_EN] && !en16_d_r;
  assign term16 = tick && st16_r == IRCT_RUN && cnt16_r == 16'h0001;
  assign cap16 = dm16 && st16_r == IRCT_RUN && evt;
  assign to16_set = term16;
  assign stop16 = term16 && !dm16 && ctl16_r[CTL_SINGLE];
  assign wr_ctl16 = wr_en && widx == IDX_WORD_CTL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl16_r <= RST_CTL;
    end else begin
      if (wr_ctl16) begin
        ctl16_r[7:6] <= wd_r[7:6];
        ctl16_r[4] <= wd_r[4];
        ctl16_r[2:0] <= wd_r[2:0];
      end
      // status set wins over a clearing write
      if (to16_set) ctl16_r[CTL_TIMEOUT] <= 1'b1;
      else if (wr_ctl16 && wd_r[CTL_TIMEOUT]) ctl16_r[CTL_TIMEOUT] <= 1'b0;
      if (cap16) ctl16_r[CTL_CAPSTAT] <= 1'b1;
      else if (wr_ctl16 && wd_r[CTL_CAPSTAT]) ctl16_r[CTL_CAPSTAT] <= 1'b0;
      if (stop16 && !wr_ctl16) ctl16_r[CTL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st16_r <= IRCT_IDLE;
      cnt16_r <= 16'h0000;
      out16_r <= 1'b1;
      en16_d_r <= 1'b0;
      cap16_r <= {RST_CAP, RST_CAP};
    end else begin
      en16_d_r <= ctl16_r[CTL_EN];
      if (cap16) cap16_r <= ~cnt16_r;
      if (!ctl16_r[CTL_EN]) begin
        st16_r <= IRCT_IDLE;
        out16_r <= !cmn_r[CMN_WORD_INIT];
      end else if (start16) begin
        st16_r <= dm16 ? IRCT_ARMED : IRCT_RUN;
        cnt16_r <= {hold16h_r, hold16l_r};
        if (!carrier) out16_r <= cmn_r[CMN_WORD_INIT];
      end else if (dm16 && st16_r == IRCT_ARMED && evt) begin
        st16_r <= IRCT_RUN;
        cnt16_r <= 16'hffff;
      end else if (cap16) begin
        cnt16_r <= 16'hffff;
      end else if (tick && st16_r == IRCT_RUN) begin
        if (cnt16_r == 16'h0000) begin
          cnt16_r <= dm16 ? 16'hffff : 16'hfffe;
        end else if (cnt16_r == 16'h0001) begin
          cnt16_r <= 16'h0000;
          if (!dm16) begin
            // carrier mode keeps the output still
            if (!carrier) out16_r <= !out16_r;
            if (ctl16_r[CTL_SINGLE]) st16_r <= IRCT_IDLE;
            else cnt16_r <= {hold16h_r, hold16l_r};
          end
        end else begin
          cnt16_r <= cnt16_r - 16'h0001;
        end
      end
    end
  end

  // ---------------- outputs ----------------
  assign byte_timer_output = out8_r;
  assign word_timer_output = cmn_r[CMN_MODE_LSB + 1] ?
                             cmn_r[CMN_MODE_LSB] : out16_r;
  assign byte_timer_pin_en = ctl8_r[CTL_PIN_EN];
  assign word_timer_pin_en = ctl16_r[CTL_PIN_EN];
  assign byte_timeout_irq = ctl8_r[CTL_TO_IE] && ctl8_r[CTL_TIMEOUT];
  assign byte_capture_irq = ctl8_r[CTL_CAP_IE] && (|edge8_r);
  assign word_timeout_irq = ctl16_r[CTL_TO_IE] && ctl16_r[CTL_TIMEOUT];
  assign word_capture_irq = ctl16_r[CTL_CAP_IE] && ctl16_r[CTL_CAPSTAT];

endmodule : irct_timers

// ### verif/irct_monitor.sv
// bus and timer output checker bound to the timer top
`timescale 1ns/1ns
module irct_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [irct_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [irct_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer outputs
  input wire logic byte_timer_output,
  input wire logic word_timer_output,
  input wire logic byte_timer_pin_en,
  input wire logic byte_timeout_irq,
  input wire logic word_timeout_irq
);
  import irct_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_hs, rd_hs, wr_ok_r, rd_ok_r;
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  // the address moves on after the handshake, so keep its map hit
  always_ff @(posedge aclk) begin
    if (wr_hs) wr_ok_r <= s_axi_awaddr[13:2] inside {[IDX_BYTE_CTL:IDX_BYTE_CAP_HI]};
    if (rd_hs) rd_ok_r <= s_axi_araddr[13:2] inside {[IDX_BYTE_CTL:IDX_BYTE_CAP_HI]};
  end
  a_reset_idle: assert property ($rose(aresetn) |-> byte_timer_output
    && word_timer_output && !byte_timer_pin_en && !byte_timeout_irq
    && !word_timeout_irq) else $error("outputs not idle after reset");
  a_aw_taken: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("address accepted twice");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer lost");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_read_answer: assert property (rd_hs |=> s_axi_rvalid && s_axi_rresp
    == (rd_ok_r ? RESP_OKAY : RESP_SLVERR) && (rd_ok_r || s_axi_rdata == 0))
    else $error("bad read answer");
  a_write_answer: assert property (wr_hs |-> ##2 s_axi_bvalid
    && s_axi_bresp == (wr_ok_r ? RESP_OKAY : RESP_SLVERR))
    else $error("bad write answer");
  a_pin_follows: assert property (wr_hs && s_axi_awaddr[13:2]
    == IDX_BYTE_CTL |-> ##2 byte_timer_pin_en == $past(s_axi_wdata[0], 2))
    else $error("pin enable not written");
  a_word_forced: assert property (wr_hs && s_axi_wdata[3]
    && s_axi_awaddr[13:2] == IDX_COMMON
    |-> ##2 word_timer_output == $past(s_axi_wdata[2], 2))
    else $error("word output not forced");
endmodule : irct_monitor

bind irct_timers irct_monitor u_mon (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .byte_timer_output, .word_timer_output, .byte_timer_pin_en,
  .byte_timeout_irq, .word_timeout_irq);

// ### verif/irct_ir_source.sv
// infrared source model: drives the chosen timer input, scrambles the rest
`timescale 1ns/1ns
module irct_ir_source (
  // clock
  input wire logic aclk,
  // level of the live source and which source is live
  input wire logic level,
  input wire logic [1:0] src,
  // timer input sources
  output logic primary_timer_input_pin,
  output logic primary_comparator_out,
  output logic primary_ir_amp_out,
  output logic alternate_timer_input_pin,
  output logic [1:0] port_three_mode_register
);
  logic junk_r = 1'h0;
  // idle sources wiggle every cycle so a wrong select never reads quiet
  always @(posedge aclk) begin
    junk_r <= !junk_r;
  end
  assign primary_timer_input_pin = (src == 2'h0) ? level : junk_r;
  assign primary_comparator_out = (src == 2'h1) ? level : junk_r;
  assign primary_ir_amp_out = (src == 2'h2) ? level : junk_r;
  assign alternate_timer_input_pin = (src == 2'h3) ? level : junk_r;
  assign port_three_mode_register = (src == 2'h3) ? 2'h0 : src;
endmodule : irct_ir_source

// ### verif/tb_top.sv
// self-checking bench for the infrared counter/timers
`timescale 1ns/1ns
module tb_top;
  import irct_pkg::*;
  typedef struct packed {
    logic [11:0] idx;
    logic [7:0] wd;
    logic [7:0] rv;
    logic [1:0] rs;
    logic bo;
    logic wo;
  } irct_row_t;
  localparam irct_row_t ROWS [13] = '{
    '{IDX_BYTE_LO_HOLD, 8'ha5, 8'ha5, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_BYTE_HI_HOLD, 8'h5a, 8'h5a, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_WORD_LO_HOLD, 8'h3c, 8'h3c, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_WORD_HI_HOLD, 8'hc3, 8'hc3, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_WORD_CAP_LO, 8'hff, 8'h00, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_BYTE_CAP_HI, 8'hff, 8'h00, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_EXT_CTL, 8'hff, 8'h10, RESP_OKAY, 1'h1, 1'h1},
    '{12'hd0c, 8'h55, 8'h00, RESP_SLVERR, 1'h1, 1'h1},
    '{IDX_COMMON, 8'h02, 8'h02, RESP_OKAY, 1'h0, 1'h1},
    '{IDX_COMMON, 8'h01, 8'h01, RESP_OKAY, 1'h1, 1'h0},
    '{IDX_COMMON, 8'h0a, 8'h0a, RESP_OKAY, 1'h0, 1'h0},
    '{IDX_COMMON, 8'h0d, 8'h0d, RESP_OKAY, 1'h1, 1'h1},
    '{IDX_COMMON, 8'h00, 8'h00, RESP_OKAY, 1'h1, 1'h1}};
  logic aclk, aresetn, level;
  logic [1:0] src, s_axi_bresp, s_axi_rresp, r;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, alternate_timer_input_pin;
  logic primary_timer_input_pin, primary_comparator_out, primary_ir_amp_out;
  logic [1:0] port_three_mode_register;
  logic byte_timer_output, word_timer_output, byte_timer_pin_en;
  logic word_timer_pin_en, byte_timeout_irq, byte_capture_irq;
  logic word_timeout_irq, word_capture_irq;
  int n_fail, checked, n;

  irct_timers u_dut (.*);
  irct_ir_source u_src (.*);

  initial begin
    aclk = 1'h0;
    forever #25 aclk = !aclk;
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic expire();
    n_fail++;
    conclude();
  endtask : expire

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] idx, input logic [7:0] v);
    int k;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    k = 0;
    // look only after an edge: the last answer may still be showing
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
      k++;
    end while (k < 40 && !(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    if (s_axi_bready) s_axi_bready <= 1'h0;
    if (!(s_axi_bvalid && s_axi_bready)) expire();
  endtask : wr

  task automatic rd(input logic [11:0] idx);
    int k;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
      k++;
    end while (k < 40 && !(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (s_axi_rready) s_axi_rready <= 1'h0;
    if (!(s_axi_rvalid && s_axi_rready)) expire();
  endtask : rd

  task automatic wait_out(input logic wsel, input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      if ((wsel ? word_timer_output : byte_timer_output) === v) break;
      @(posedge aclk);
    end
    if (n == lim) expire();
  endtask : wait_out

  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  initial begin
    {aresetn, level, src, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    do_reset();
    for (int i = 0; i < 13; i++) begin
      wr(ROWS[i].idx, ROWS[i].wd);
      chk(r, ROWS[i].rs);
      rd(ROWS[i].idx);
      chk(d, {24'h0, ROWS[i].rv});
      chk(r, ROWS[i].rs);
      chk(byte_timer_output, ROWS[i].bo);
      chk(word_timer_output, ROWS[i].wo);
    end
    // carrier mode off again, it would freeze the word output
    wr(IDX_EXT_CTL, 8'h00);
    // no start count of one is ever programmed
    wr(IDX_BYTE_LO_HOLD, 8'h03);
    wr(IDX_BYTE_CTL, 8'hc2);
    chk(byte_timer_output, 1'h0);
    wait_out(1'h0, 1'h1, 20);
    @(posedge aclk);
    chk(byte_timeout_irq, 1'h1);
    rd(IDX_BYTE_CTL);
    chk(d, 32'h62);
    // timer already stopped, so this write clears status and also the single and timeout enable bits
    wr(IDX_BYTE_CTL, 8'h20);
    wr(IDX_BYTE_LO_HOLD, 8'h02);
    wr(IDX_BYTE_HI_HOLD, 8'h04);
    wr(IDX_BYTE_CTL, 8'h82);
    wait_out(1'h0, 1'h1, 40);
    @(posedge aclk);
    chk(byte_timeout_irq, 1'h0);
    wait_out(1'h0, 1'h0, 40);
    @(posedge aclk);
    chk(byte_timeout_irq, 1'h1);
    // stop first, clear status in a second write
    wr(IDX_BYTE_CTL, 8'h00);
    wr(IDX_BYTE_CTL, 8'h20);
    chk(byte_timer_output, 1'h1);
    wr(IDX_BYTE_LO_HOLD, 8'h00);
    wr(IDX_BYTE_CTL, 8'hc0);
    wait_out(1'h0, 1'h1, 600);
    chk(n inside {[500:520]}, 1'h1);
    wr(IDX_WORD_LO_HOLD, 8'h02);
    wr(IDX_WORD_HI_HOLD, 8'h01);
    wr(IDX_WORD_CTL, 8'hc3);
    chk(word_timer_output, 1'h0);
    chk(word_timer_pin_en, 1'h1);
    wait_out(1'h1, 1'h1, 600);
    chk(n inside {[506:524]}, 1'h1);
    @(posedge aclk);
    chk(word_timeout_irq, 1'h1);
    rd(IDX_WORD_CTL);
    chk(d, 32'h63);
    // both byte holds all ones before demodulation
    wr(IDX_BYTE_LO_HOLD, 8'hff);
    wr(IDX_BYTE_HI_HOLD, 8'hff);
    wr(IDX_COMMON, 8'h20);
    wr(IDX_BYTE_CTL, 8'h94);
    level <= 1'h1;
    repeat (20) @(posedge aclk);
    level <= 1'h0;
    repeat (20) @(posedge aclk);
    level <= 1'h1;
    repeat (6) @(posedge aclk);
    chk(byte_capture_irq, 1'h1);
    rd(IDX_BYTE_CAP_HI);
    chk(d inside {[9:11]}, 1'h1);
    rd(IDX_BYTE_CAP_LO);
    chk(d inside {[9:11]}, 1'h1);
    rd(IDX_COMMON);
    chk(d, 32'h23);
    // alternate pin, rising edges only, filter of two cycles
    src <= 2'h3;
    wr(IDX_COMMON, 8'h44);
    wr(IDX_WORD_CTL, 8'h94);
    level <= 1'h0;
    repeat (10) @(posedge aclk);
    level <= 1'h1;
    repeat (10) @(posedge aclk);
    // a one-cycle dip must not reach the edge logic
    level <= 1'h0;
    @(posedge aclk);
    level <= 1'h1;
    repeat (9) @(posedge aclk);
    level <= 1'h0;
    repeat (20) @(posedge aclk);
    level <= 1'h1;
    repeat (8) @(posedge aclk);
    chk(word_capture_irq, 1'h1);
    rd(IDX_WORD_CAP_LO);
    chk(d inside {[18:21]}, 1'h1);
    do_reset();
    for (int i = 0; i < 12; i++) begin
      rd(IDX_BYTE_CTL + 12'(i));
      chk(d, 32'h0);
    end
    conclude();
  end
endmodule : tb_top
